// ### rtl/rtc_pkg.sv
package rtc_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_IDEALITY_ADJUST = 8'h23;
  localparam logic [7:0] ADDR_MAKER_IDENTITY = 8'hfe;
  localparam logic [7:0] IDEALITY_ADJUST_RST = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  // ---------------------------------------------------------------
  // Ideality arithmetic
  // ---------------------------------------------------------------
  localparam real ETA_TRIM = 1.008;
  localparam real ETA_STEP = 0.000483;
  localparam int ETA_DEN = 2088;
  localparam logic [11:0] ETA_DEN_12 = 12'h828;
  localparam int RECIP_SHIFT = 24;
  localparam logic [12:0] RECIP_DEN = 13'h1f63;
  // ---------------------------------------------------------------
  // Result formats, 1/16 degree per code
  // ---------------------------------------------------------------
  localparam int TEMP_W = 12;
  localparam int KELVIN_W = 13;
  localparam logic signed [16:0] KELVIN_ZERO_Q4 = 17'sh01112;
  localparam logic signed [16:0] STD_MIN = -17'sh00800;
  localparam logic signed [16:0] STD_MAX = 17'sh007ff;
  localparam logic signed [16:0] EXT_BIAS = 17'sh00400;
  localparam logic signed [16:0] EXT_MIN = 17'sh00000;
  localparam logic signed [16:0] EXT_MAX = 17'sh00fff;
  // ---------------------------------------------------------------
  // Excitation
  // ---------------------------------------------------------------
  localparam int EXC_LOW_NA = 7500;
  localparam int EXC_HIGH_NA = 120000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int EXC_SETTLE_NS = 64;
  localparam int EXC_SETTLE_CYC = (EXC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum {
    RTC_IDLE,
    RTC_EXC_LOW,
    RTC_EXC_HIGH,
    RTC_SCALE,
    RTC_FINISH
  } rtc_state_t;
endpackage

// ### rtl/rtc_remote_temp_calibration.sv
`timescale 1ns/10ps
// Contract
// - Effective ideality is 1.008*2088/(2088+adjust code) for remote conversions.
// - Adjust code is 8-bit two's complement, -128 to 127; host writes signed form.
// - Ideality adjust register is read/write at pointer 23h.
// - Adjust register resets to 00h, leaving trimmed default ideality.
// - One adjust step changes effective ideality by about 0.000483.
// - Stored remote offset, in result format, is added on every remote conversion.
// - Remote transistor excited 7.5 uA then 120 uA; temperature from delta VBE.
// - Read at pointer FEh returns fixed 8-bit maker identity code.
// - Results and offset use standard format when range bit 0, extended when 1.
module rtc_remote_temp_calibration
  import rtc_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h3c,  // Arbitrary value
  parameter int SETTLE_CYC = EXC_SETTLE_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Pointer register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Calibration settings
  input wire logic range_ext_i,
  input wire logic [TEMP_W-1:0] remote_offset_i,
  // Conversion control and front end
  input wire logic conv_start_i,
  input wire logic fe_valid_i,
  input wire logic [KELVIN_W-1:0] fe_kelvin_i,
  output logic exc_en_o,
  output logic exc_high_o,
  output logic conv_busy_o,
  // Remote result
  output logic [TEMP_W-1:0] remote_result_o,
  output logic remote_valid_o
);

  // Each current phase needs two cycles and must fit the 16-bit phase counter
  if (SETTLE_CYC < 2 || SETTLE_CYC > 65535) begin : g_bad_settle
    $error("SETTLE_CYC out of range");
  end

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [7:0] ideality_adjust_reg;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ideality_adjust_reg <= IDEALITY_ADJUST_RST;
    end else if (reg_wr_i && reg_addr_i == ADDR_IDEALITY_ADJUST) begin
      ideality_adjust_reg <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= RDATA_UNMAPPED;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        case (reg_addr_i)
          ADDR_IDEALITY_ADJUST: reg_rdata_o <= ideality_adjust_reg;
          ADDR_MAKER_IDENTITY: reg_rdata_o <= MAKER_ID;
          default: reg_rdata_o <= RDATA_UNMAPPED;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Excitation sequence
  // ---------------------------------------------------------------
  rtc_state_t state_reg;
  logic [15:0] phase_cnt_reg;
  logic [KELVIN_W-1:0] kelvin_reg;
  logic [24:0] prod_reg;
  logic phase_done;

  assign phase_done = (phase_cnt_reg == 16'(SETTLE_CYC - 1));

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= RTC_IDLE;
      phase_cnt_reg <= 16'h0000;
    end else begin
      case (state_reg)
        RTC_IDLE: begin
          phase_cnt_reg <= 16'h0000;
          if (conv_start_i) begin
            state_reg <= RTC_EXC_LOW;
          end
        end
        RTC_EXC_LOW: begin
          phase_cnt_reg <= phase_done ? 16'h0000 : phase_cnt_reg + 16'h0001;
          if (phase_done) begin
            state_reg <= RTC_EXC_HIGH;
          end
        end
        RTC_EXC_HIGH: begin
          if (!phase_done) begin
            phase_cnt_reg <= phase_cnt_reg + 16'h0001;
          end else if (fe_valid_i) begin
            state_reg <= RTC_SCALE;
          end
        end
        RTC_SCALE: state_reg <= RTC_FINISH;
        RTC_FINISH: state_reg <= RTC_IDLE;
        default: state_reg <= RTC_IDLE;
      endcase
    end
  end

  // Low current first, then high current, while converting
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      exc_en_o <= 1'b0;
      exc_high_o <= 1'b0;
      conv_busy_o <= 1'b0;
    end else begin
      exc_en_o <= (state_reg == RTC_IDLE) ? conv_start_i :
                  (state_reg == RTC_EXC_LOW) ||
                  (state_reg == RTC_EXC_HIGH && !(phase_done && fe_valid_i));
      exc_high_o <= (state_reg == RTC_EXC_LOW && phase_done) ||
                    (state_reg == RTC_EXC_HIGH && !(phase_done && fe_valid_i));
      conv_busy_o <= (state_reg == RTC_IDLE) ? conv_start_i : (state_reg != RTC_FINISH);
    end
  end

  // ---------------------------------------------------------------
  // Ideality correction and offset
  // ---------------------------------------------------------------
  // The front end reports absolute temperature computed with the trimmed
  // ideality; rescaling by (2088+N)/2088 applies the effective ideality.
  logic [11:0] eta_den;
  logic [37:0] scaled_full;
  logic signed [16:0] kelvin_scaled;
  logic signed [16:0] offset_term;
  logic signed [16:0] sum;
  logic signed [16:0] fmt_min;
  logic signed [16:0] fmt_max;

  assign eta_den = ETA_DEN_12 + {{4{ideality_adjust_reg[7]}}, ideality_adjust_reg};
  assign scaled_full = 38'(prod_reg) * 38'(RECIP_DEN);
  assign kelvin_scaled = 17'($signed({3'b000, scaled_full[RECIP_SHIFT+13:RECIP_SHIFT]}));
  // Extended format: the bias of result and offset cancel, so the offset is unsigned
  assign offset_term = range_ext_i ? $signed({5'b00000, remote_offset_i}) :
                       $signed({{5{remote_offset_i[TEMP_W-1]}}, remote_offset_i});
  assign sum = kelvin_scaled - KELVIN_ZERO_Q4 + offset_term;
  assign fmt_min = range_ext_i ? EXT_MIN : STD_MIN;
  assign fmt_max = range_ext_i ? EXT_MAX : STD_MAX;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      kelvin_reg <= '0;
      prod_reg <= '0;
    end else begin
      if (state_reg == RTC_EXC_HIGH && phase_done && fe_valid_i) begin
        kelvin_reg <= fe_kelvin_i;
      end
      if (state_reg == RTC_SCALE) begin
        prod_reg <= 25'(kelvin_reg) * 25'(eta_den);
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      remote_result_o <= '0;
      remote_valid_o <= 1'b0;
    end else begin
      remote_valid_o <= (state_reg == RTC_FINISH);
      if (state_reg == RTC_FINISH) begin
        if (sum < fmt_min) begin
          remote_result_o <= fmt_min[TEMP_W-1:0];
        end else if (sum > fmt_max) begin
          remote_result_o <= fmt_max[TEMP_W-1:0];
        end else begin
          remote_result_o <= sum[TEMP_W-1:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_adj_write;
    reg_wr_i && reg_addr_i == ADDR_IDEALITY_ADJUST;
  endsequence

  property p_adj_readback;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      s_adj_write ##1 (reg_rd_i && !reg_wr_i && reg_addr_i == ADDR_IDEALITY_ADJUST)
      |=> reg_rvalid_o && reg_rdata_o == $past(reg_wdata_i, 2);
  endproperty
  a_adj_readback: assert property (p_adj_readback) else $error("adjust readback wrong");

  property p_maker_id;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      reg_rd_i && reg_addr_i == ADDR_MAKER_IDENTITY |=> reg_rdata_o == MAKER_ID;
  endproperty
  a_maker_id: assert property (p_maker_id) else $error("maker identity wrong");

  property p_adj_reset;
    @(posedge clk_sys_i) $rose(rst_b_i) |-> ideality_adjust_reg == IDEALITY_ADJUST_RST;
  endproperty
  a_adj_reset: assert property (p_adj_reset) else $error("adjust not cleared by reset");

  property p_eta_den;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      $signed({1'b0, eta_den}) == 13'sd2088 + $signed(ideality_adjust_reg);
  endproperty
  a_eta_den: assert property (p_eta_den) else $error("ideality denominator wrong");

  sequence s_low_phase;
    exc_en_o && !exc_high_o;
  endsequence

  property p_low_before_high;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      $rose(exc_en_o) |-> s_low_phase ##1 s_low_phase;
  endproperty
  a_low_before_high: assert property (p_low_before_high) else $error("high before low");

  property p_high_after_low;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      $rose(exc_high_o) |-> $past(exc_en_o) && !$past(exc_high_o);
  endproperty
  a_high_after_low: assert property (p_high_after_low) else $error("high without low");

  property p_saturate;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      state_reg == RTC_FINISH && sum > fmt_max |=> remote_result_o == $past(fmt_max[11:0]);
  endproperty
  a_saturate: assert property (p_saturate) else $error("result wrapped high");

  property p_offset_added;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      state_reg == RTC_FINISH && sum >= fmt_min && sum <= fmt_max
      |=> remote_valid_o && remote_result_o == $past(sum[11:0]);
  endproperty
  a_offset_added: assert property (p_offset_added) else $error("offset sum wrong");

  property p_ext_nonneg;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      state_reg == RTC_FINISH && range_ext_i && sum < 0
      |=> remote_result_o == 12'h000;
  endproperty
  a_ext_nonneg: assert property (p_ext_nonneg) else $error("extended floor wrong");

endmodule // rtc_remote_temp_calibration

// ### verif/rtc_fe_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Remote junction and front end
// ---------------------------------------------------------------
module rtc_fe_model (
  // Clock
  input wire logic clk_sys_i,
  // Excitation from the device, junction temperature from the testbench
  input wire logic exc_en_i,
  input wire logic exc_high_i,
  input wire logic [12:0] kelvin_i,
  // Measurement to the device
  output logic fe_valid_o,
  output logic [12:0] fe_kelvin_o
);
  logic seen_low = 1'b0;
  logic [12:0] junk = 13'h0aaa;
  always @(posedge clk_sys_i) begin
    junk <= ~junk;
    if (!exc_en_i) begin
      seen_low <= 1'b0;
    end else if (!exc_high_i) begin
      seen_low <= 1'b1;
    end
  end
  // A reading exists only after a low then a high current phase
  assign fe_valid_o = exc_en_i && exc_high_i && seen_low;
  // Outside a reading the value keeps changing
  assign fe_kelvin_o = fe_valid_o ? kelvin_i : junk;
endmodule // rtc_fe_model

// ### verif/testbench.sv
`timescale 1ns/10ps
module testbench;
  import rtc_pkg::*;
  localparam logic [7:0] ID_VAL = 8'h5a;  // Arbitrary identity value
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic reg_rvalid_o;
  logic range_ext_i = 1'b0;
  logic [11:0] remote_offset_i = 12'h000;
  logic conv_start_i = 1'b0;
  logic fe_valid_i;
  logic [12:0] fe_kelvin_i;
  logic [12:0] kelvin_set = 13'h0000;
  logic exc_en_o;
  logic exc_high_o;
  logic conv_busy_o;
  logic remote_valid_o;
  logic [11:0] remote_result_o;
  logic [7:0] adj_tab[6] = '{8'h80, 8'h7f, 8'h00, 8'hff, 8'h0a, 8'hf6};
  int n_errors = 0;
  int comparisons = 0;
  // ---------------------------------------------------------------
  // Device and far side
  // ---------------------------------------------------------------
  rtc_remote_temp_calibration #(.MAKER_ID(ID_VAL), .SETTLE_CYC(2)) dut (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .range_ext_i(range_ext_i),
    .remote_offset_i(remote_offset_i), .conv_start_i(conv_start_i),
    .fe_valid_i(fe_valid_i), .fe_kelvin_i(fe_kelvin_i), .exc_en_o(exc_en_o),
    .exc_high_o(exc_high_o), .conv_busy_o(conv_busy_o),
    .remote_result_o(remote_result_o), .remote_valid_o(remote_valid_o));
  rtc_fe_model fe (
    .clk_sys_i(clk_sys_i), .exc_en_i(exc_en_o), .exc_high_i(exc_high_o),
    .kelvin_i(kelvin_set), .fe_valid_o(fe_valid_i), .fe_kelvin_o(fe_kelvin_i));
  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic note(input logic bad, input string what);
    comparisons++;
    if (bad) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
    note(got !== exp, what);
  endtask
  task automatic cmp_temp(input logic [11:0] got, input logic [11:0] exp, input string what);
    note(got !== exp, what);
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    cmp_reg({7'h00, reg_rvalid_o}, 8'h01, "read answer");
    d = reg_rdata_o;
  endtask
  // Write immediately followed by a read of the same pointer
  task automatic reg_write_read(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    cmp_reg({7'h00, reg_rvalid_o}, 8'h01, "read answer");
    q = reg_rdata_o;
  endtask
  task automatic convert(input int k, input int n, input logic [11:0] off, input logic ext);
    longint p;
    int t;
    logic saw_low;
    logic order_ok;
    logic busy_ok;
    p = longint'(k) * (ETA_DEN + n) * 8035;
    t = int'(p >>> 24) - 4370 + (ext ? int'(off) : int'($signed(off)));
    if (t < (ext ? 0 : -2048)) t = ext ? 0 : -2048;
    if (t > (ext ? 4095 : 2047)) t = ext ? 4095 : 2047;
    @(posedge clk_sys_i);
    kelvin_set <= 13'(k);
    range_ext_i <= ext;
    remote_offset_i <= off;
    conv_start_i <= 1'b1;
    @(posedge clk_sys_i);
    conv_start_i <= 1'b0;
    saw_low = 1'b0;
    order_ok = 1'b1;
    busy_ok = 1'b1;
    for (int i = 0; i < 200; i++) begin
      @(posedge clk_sys_i);
      #1;
      if (exc_en_o === 1'b1 && exc_high_o === 1'b0) saw_low = 1'b1;
      if (exc_high_o === 1'b1 && !saw_low) order_ok = 1'b0;
      if (remote_valid_o !== 1'b1 && conv_busy_o !== 1'b1) busy_ok = 1'b0;
      if (remote_valid_o === 1'b1) break;
    end
    cmp_reg({6'h00, remote_valid_o, order_ok & saw_low}, 8'h03, "excitation");
    cmp_reg({7'h00, busy_ok & (conv_busy_o === 1'b0)}, 8'h01, "busy");
    cmp_temp(remote_result_o, 12'(t), "remote result");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    #200000;
    n_errors++;
    $display("wrong value at %0t: run hung", $time);
    tally_and_finish();
  end
  initial begin
    logic [7:0] d;
    void'($urandom(32'hf7ea));
    repeat (4) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    reg_read(ADDR_IDEALITY_ADJUST, d);
    cmp_reg(d, IDEALITY_ADJUST_RST, "adjust after reset");
    convert(4370 + 400, 0, 12'h000, 1'b0);
    reg_read(ADDR_MAKER_IDENTITY, d);
    cmp_reg(d, ID_VAL, "identity");
    reg_write(ADDR_MAKER_IDENTITY, 8'h00);
    reg_read(ADDR_MAKER_IDENTITY, d);
    cmp_reg(d, ID_VAL, "identity after write");
    reg_read(8'h24, d);
    cmp_reg(d, RDATA_UNMAPPED, "unmapped read");
    $display("test registers done");
    foreach (adj_tab[j]) begin
      reg_write_read(ADDR_IDEALITY_ADJUST, adj_tab[j], d);
      cmp_reg(d, adj_tab[j], "adjust readback");
      convert(3000 + int'($urandom_range(4000)), int'($signed(adj_tab[j])),
              12'($urandom), j[0]);
    end
    $display("test adjust sweep done");
    convert(8000, -10, 12'h7ff, 1'b0);
    convert(3000, -10, 12'h800, 1'b0);
    convert(3000, -10, 12'h000, 1'b1);
    $display("test saturation done");
    @(posedge clk_sys_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    reg_read(ADDR_IDEALITY_ADJUST, d);
    cmp_reg(d, IDEALITY_ADJUST_RST, "adjust after second reset");
    convert(4370 + 400, 0, 12'h000, 1'b0);
    $display("test reset done");
    tally_and_finish();
  end
endmodule // testbench
